// File: hw/hrb_defines.svh
`ifndef HRB_DEFINES_SVH
`define HRB_DEFINES_SVH
// Summary of operation
// - Three identical per-phase second-harmonic decision paths
// - Per phase compare harmonic/fundamental ratio to threshold
// - High ratio sets restraint at once, starts timer
// - Ratio high 25 ticks (25 ms at 50 Hz) starts drop-off extension
// - Second-harmonic restraint blocks only during inrush or fault
// - OR gated phase second-harmonic decisions into summary flag
// - Fifth path same logic, gated by minimum current
// - Cross-block off: element blocked by own restraint only
// - Cross-block on: any restraint blocks all elements
// - Cross-blocking ends when time limit expires
// - After timeout, restrained phase keeps blocking itself
// - Cross-block enable defaults true, bounded by limit
// - Cross-block limit 100..60000 ms, default 5000
// - Drop-off extends restraint 15 ticks (15 ms at 50 Hz) when qualified
// - Thresholds 5..50 percent, defaults 15 and 25
// - Inrush condition input comes from upstream detector
// - External-fault condition input comes from upstream detector

// APB register byte offsets
`define HRB_OFS_CTRL      8'h00
`define HRB_OFS_THR2      8'h04
`define HRB_OFS_THR5      8'h08
`define HRB_OFS_XLIMIT    8'h0c
`define HRB_OFS_MIN_DIFF  8'h10
`define HRB_OFS_STATUS    8'h14

// CTRL field positions
`define HRB_CTRL_XEN_BIT  0
`define HRB_CTRL_F60_BIT  1

// STATUS field positions
`define HRB_ST_H2_LSB     0
`define HRB_ST_INR_LSB    3
`define HRB_ST_H5_LSB     6
`define HRB_ST_ANY2_BIT   9
`define HRB_ST_ANY5_BIT   10
`define HRB_ST_XB_BIT     11

// Reset values and legal ranges of the settings
`define HRB_XEN_RST       1'b1
`define HRB_F60_RST       1'b0
`define HRB_THR2_RST      7'h0f
`define HRB_THR5_RST      7'h19
`define HRB_THR_MIN       7'h05
`define HRB_THR_MAX       7'h32
`define HRB_XLIMIT_RST    16'h1388
`define HRB_XLIMIT_MIN    16'h0064
`define HRB_XLIMIT_MAX    16'hea60
`define HRB_MIN_DIFF_RST  16'h0000
`define HRB_PERCENT       7'h64

// Timing: clock period, tick periods and timer lengths in ticks
`define HRB_CLK_NS        50
`define HRB_MS_NS         1000000
`define HRB_TICK60_NS     833333
`define HRB_QUAL_MS       25
`define HRB_DROP_MS       15
`define HRB_QUAL_TICKS    5'h19
`define HRB_DROP_TICKS    5'h0f
`endif

// File: hw/hrb_pkg.sv
package hrb_pkg;
	// Cross-blocking sequencer states
	typedef enum logic [1:0] {
		HRB_XB_IDLE    = 2'b00,
		HRB_XB_ACTIVE  = 2'b01,
		HRB_XB_EXPIRED = 2'b10
	} hrb_xb_state_t;

	// Tick divider state
	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} hrb_tick_st_t;

	// One harmonic decision path
	typedef struct packed {
		logic [4:0] qual_cnt;
		logic [4:0] drop_cnt;
		logic       qualified;
		logic       restraint;
	} hrb_path_st_t;

	// Top-level state: settings, bus answer, sequencer, outputs
	typedef struct packed {
		logic          xen;
		logic          f60;
		logic [6:0]    thr2;
		logic [6:0]    thr5;
		logic [15:0]   xlimit;
		logic [15:0]   min_diff;
		logic [31:0]   prdata;
		logic          pslverr;
		hrb_xb_state_t xb_state;
		logic [15:0]   xb_cnt;
		logic          any2;
		logic          any5;
		logic [2:0]    block;
		logic [2:0]    trip;
	} hrb_top_st_t;
endpackage : hrb_pkg

// File: hw/hrb_tick_gen.sv
`include "hrb_defines.svh"
// Free-running divider giving a one-cycle tick every period_in clocks
module hrb_tick_gen (
	input  wire logic        sys_clk_in,
	input  wire logic        srst_in,
	input  wire logic [15:0] period_in,
	output logic             tick_out
);
	hrb_pkg::hrb_tick_st_t st;      // Registered state
	hrb_pkg::hrb_tick_st_t next_st; // Next state

	// Count to period-1 then wrap; a shorter new period wraps at once
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.cnt >= period_in - 16'h0001) begin
			next_st.cnt  = 16'h0000;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 16'h0001;
		end
	end

	// State register
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_out = st.tick;
endmodule : hrb_tick_gen

// File: hw/hrb_harm_path.sv
`include "hrb_defines.svh"
// One harmonic restraint decision for one phase
module hrb_harm_path #(
	parameter int MAG_W = 16
) (
	input  wire logic             sys_clk_in,
	input  wire logic             srst_in,
	input  wire logic             tick_in,    // Power-cycle based tick
	input  wire logic             enable_in,  // Gate on the high decision
	input  wire logic [MAG_W-1:0] fund_in,    // Fundamental magnitude
	input  wire logic [MAG_W-1:0] harm_in,    // Harmonic magnitude
	input  wire logic [6:0]       thr_in,     // Threshold in percent
	output logic                  restraint_out
);
	hrb_pkg::hrb_path_st_t st;      // Registered state
	hrb_pkg::hrb_path_st_t next_st; // Next state
	logic [MAG_W+7:0]      harm_pct; // Harmonic scaled by 100
	logic [MAG_W+7:0]      thr_fund; // Threshold times fundamental
	logic                  high;     // Ratio above threshold

	// Ratio compare by cross-multiplication, no divider needed
	always_comb begin
		harm_pct = (MAG_W+8)'(harm_in) * (MAG_W+8)'(`HRB_PERCENT);
		thr_fund = (MAG_W+8)'(fund_in) * (MAG_W+8)'(thr_in);
		high     = enable_in && (harm_pct > thr_fund);
	end

	// Qualification and drop-off timers counted in ticks
	always_comb begin
		next_st = st;
		if (high) begin
			// Restraint at once, qualification timer runs
			next_st.restraint = 1'b1;
			next_st.drop_cnt  = 5'h00;
			if (tick_in && st.qual_cnt < `HRB_QUAL_TICKS) begin
				next_st.qual_cnt = st.qual_cnt + 5'h01;
			end
			if (st.qual_cnt >= `HRB_QUAL_TICKS) begin
				next_st.qualified = 1'b1;
			end
		end else begin
			// Any gap restarts qualification
			next_st.qual_cnt = 5'h00;
			if (st.qualified && st.drop_cnt < `HRB_DROP_TICKS) begin
				// Hold restraint while the drop-off timer runs
				next_st.restraint = 1'b1;
				if (tick_in) begin
					next_st.drop_cnt = st.drop_cnt + 5'h01;
				end
			end else begin
				next_st.restraint = 1'b0;
				next_st.qualified = 1'b0;
				next_st.drop_cnt  = 5'h00;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign restraint_out = st.restraint;
endmodule : hrb_harm_path

// File: hw/hrb_top.sv
`include "hrb_defines.svh"
// Harmonic restraint and cross-blocking for a three-phase
// differential element, with settings and status over APB
module hrb_top #(
	parameter int MAG_W          = 16,                             // Magnitude width
	parameter int CLKS_PER_MS    = `HRB_MS_NS / `HRB_CLK_NS,       // Clocks per millisecond
	parameter int CLKS_PER_TK60  = `HRB_TICK60_NS / `HRB_CLK_NS    // Clocks per 60 Hz tick
) (
	input  wire logic               sys_clk_in,
	input  wire logic               srst_in,
	// APB slave
	input  wire logic               psel_in,
	input  wire logic               penable_in,
	input  wire logic               pwrite_in,
	input  wire logic [7:0]         paddr_in,
	input  wire logic [31:0]        pwdata_in,
	output logic [31:0]             prdata_out,
	output logic                    pready_out,
	output logic                    pslverr_out,
	// Harmonic estimator magnitudes, one lane per phase
	input  wire logic [3*MAG_W-1:0] fund_mag_in,
	input  wire logic [3*MAG_W-1:0] second_mag_in,
	input  wire logic [3*MAG_W-1:0] fifth_mag_in,
	// Gating conditions from upstream detectors
	input  wire logic               inrush_cond_in,
	input  wire logic               ext_fault_cond_in,
	// Measuring element start requests
	input  wire logic [2:0]         elem_start_in,
	// Decisions
	output logic [2:0]              second_harm_restraint_out,
	output logic [2:0]              inrush_restraint_out,
	output logic [2:0]              fifth_harm_restraint_out,
	output logic                    any_phase_second_harm_restraint_out,
	output logic                    any_phase_fifth_harm_restraint_out,
	output logic                    cross_block_active_out,
	output logic [2:0]              elem_block_out,
	output logic [2:0]              elem_trip_req_out
);
	hrb_pkg::hrb_top_st_t st;      // Registered state
	hrb_pkg::hrb_top_st_t next_st; // Next state

	logic        ms_tick;       // One pulse per millisecond
	logic        cyc_tick;      // One pulse per twentieth of a power cycle
	logic [15:0] cyc_period;    // Divider for the cycle tick
	logic [2:0]  h2_raw;        // Ungated second-harmonic decisions
	logic [2:0]  h5_raw;        // Fifth-harmonic decisions
	logic [2:0]  inr;           // Second harmonic gated by condition
	logic [2:0]  own_block;     // Phase blocked by its own harmonics
	logic        any_restraint; // Some phase is restrained
	logic        gate2;         // Inrush or external fault active
	logic        setup;         // APB setup phase
	logic        access;        // APB access phase
	logic        wr;            // Write taking effect this edge
	logic [31:0] status_word;   // Live status image
	logic [6:0]  wr_thr;        // Written threshold after clamping
	logic [15:0] wr_lim;        // Written limit after clamping

	// Tick for the harmonic timers scales with system frequency,
	// so 25 and 15 ticks become 20.83 ms and 12.5 ms at 60 Hz
	assign cyc_period = st.f60 ? 16'(CLKS_PER_TK60) : 16'(CLKS_PER_MS);

	// Millisecond tick for the cross-blocking limit
	hrb_tick_gen u_ms_tick (
		.sys_clk_in (sys_clk_in),
		.srst_in    (srst_in),
		.period_in  (16'(CLKS_PER_MS)),
		.tick_out   (ms_tick)
	);

	// Frequency dependent tick for qualification and drop-off
	hrb_tick_gen u_cyc_tick (
		.sys_clk_in (sys_clk_in),
		.srst_in    (srst_in),
		.period_in  (cyc_period),
		.tick_out   (cyc_tick)
	);

	// Three phases, each with a second and a fifth harmonic path
	for (genvar p = 0; p < 3; p++) begin : g_phase
		logic fund_ok; // Minimum differential current reached

		assign fund_ok = fund_mag_in[p*MAG_W +: MAG_W] >= MAG_W'(st.min_diff);

		// Second harmonic, identical per phase
		hrb_harm_path #(
			.MAG_W (MAG_W)
		) u_h2 (
			.sys_clk_in    (sys_clk_in),
			.srst_in       (srst_in),
			.tick_in       (cyc_tick),
			.enable_in     (1'b1),
			.fund_in       (fund_mag_in[p*MAG_W +: MAG_W]),
			.harm_in       (second_mag_in[p*MAG_W +: MAG_W]),
			.thr_in        (st.thr2),
			.restraint_out (h2_raw[p])
		);

		// Fifth harmonic gated only by the minimum current
		hrb_harm_path #(
			.MAG_W (MAG_W)
		) u_h5 (
			.sys_clk_in    (sys_clk_in),
			.srst_in       (srst_in),
			.tick_in       (cyc_tick),
			.enable_in     (fund_ok),
			.fund_in       (fund_mag_in[p*MAG_W +: MAG_W]),
			.harm_in       (fifth_mag_in[p*MAG_W +: MAG_W]),
			.thr_in        (st.thr5),
			.restraint_out (h5_raw[p])
		);
	end

	// Condition gating and per-phase own blocking
	always_comb begin
		// Both conditions arrive ready-made from upstream detectors
		gate2         = inrush_cond_in || ext_fault_cond_in;
		inr           = h2_raw & {3{gate2}};
		own_block     = inr | h5_raw;
		any_restraint = |own_block;
	end

	// APB phase decode
	always_comb begin
		setup  = psel_in && !penable_in;
		access = psel_in && penable_in;
		wr     = access && pwrite_in;
	end

	// Status image assembled from live decisions
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`HRB_ST_H2_LSB +: 3]  = h2_raw;
		status_word[`HRB_ST_INR_LSB +: 3] = inr;
		status_word[`HRB_ST_H5_LSB +: 3]  = h5_raw;
		status_word[`HRB_ST_ANY2_BIT]     = st.any2;
		status_word[`HRB_ST_ANY5_BIT]     = st.any5;
		status_word[`HRB_ST_XB_BIT]       = (st.xb_state == hrb_pkg::HRB_XB_ACTIVE);
	end

	// Clamp written settings into their legal ranges
	always_comb begin
		if (pwdata_in[31:7] != 25'h0 || pwdata_in[6:0] > `HRB_THR_MAX) begin
			wr_thr = `HRB_THR_MAX;
		end else if (pwdata_in[6:0] < `HRB_THR_MIN) begin
			wr_thr = `HRB_THR_MIN;
		end else begin
			wr_thr = pwdata_in[6:0];
		end
		if (pwdata_in[31:16] != 16'h0 || pwdata_in[15:0] > `HRB_XLIMIT_MAX) begin
			wr_lim = `HRB_XLIMIT_MAX;
		end else if (pwdata_in[15:0] < `HRB_XLIMIT_MIN) begin
			wr_lim = `HRB_XLIMIT_MIN;
		end else begin
			wr_lim = pwdata_in[15:0];
		end
	end

	// Next-state logic: bus slave, cross-block sequencer, outputs
	always_comb begin
		next_st = st;

		// Read data and error are captured in setup, so the data
		// output stays a flop while the access phase needs no wait
		if (setup) begin
			next_st.prdata  = 32'h0000_0000;
			next_st.pslverr = 1'b0;
			unique case (paddr_in)
				`HRB_OFS_CTRL: begin
					next_st.prdata[`HRB_CTRL_XEN_BIT] = st.xen;
					next_st.prdata[`HRB_CTRL_F60_BIT] = st.f60;
				end
				`HRB_OFS_THR2: begin
					next_st.prdata[6:0] = st.thr2;
				end
				`HRB_OFS_THR5: begin
					next_st.prdata[6:0] = st.thr5;
				end
				`HRB_OFS_XLIMIT: begin
					next_st.prdata[15:0] = st.xlimit;
				end
				`HRB_OFS_MIN_DIFF: begin
					next_st.prdata[15:0] = st.min_diff;
				end
				`HRB_OFS_STATUS: begin
					next_st.prdata = status_word;
				end
				default: begin
					// Unmapped address reads zero and flags an error
					next_st.pslverr = 1'b1;
				end
			endcase
		end

		// Writes land at the access edge; status is read-only
		if (wr) begin
			unique case (paddr_in)
				`HRB_OFS_CTRL: begin
					next_st.xen = pwdata_in[`HRB_CTRL_XEN_BIT];
					next_st.f60 = pwdata_in[`HRB_CTRL_F60_BIT];
				end
				`HRB_OFS_THR2: begin
					next_st.thr2 = wr_thr;
				end
				`HRB_OFS_THR5: begin
					next_st.thr5 = wr_thr;
				end
				`HRB_OFS_XLIMIT: begin
					next_st.xlimit = wr_lim;
				end
				`HRB_OFS_MIN_DIFF: begin
					next_st.min_diff = pwdata_in[15:0];
				end
				default: begin
					// Status and unmapped writes are dropped
				end
			endcase
		end

		// Cross-blocking sequencer; a new episode needs all phases
		// to drop first, so one long event cannot re-arm it
		unique case (st.xb_state)
			hrb_pkg::HRB_XB_IDLE: begin
				next_st.xb_cnt = 16'h0000;
				if (st.xen && any_restraint) begin
					next_st.xb_state = hrb_pkg::HRB_XB_ACTIVE;
				end
			end
			hrb_pkg::HRB_XB_ACTIVE: begin
				if (!st.xen || !any_restraint) begin
					next_st.xb_state = hrb_pkg::HRB_XB_IDLE;
				end else if (ms_tick) begin
					if (st.xb_cnt + 16'h0001 >= st.xlimit) begin
						next_st.xb_state = hrb_pkg::HRB_XB_EXPIRED;
					end else begin
						next_st.xb_cnt = st.xb_cnt + 16'h0001;
					end
				end
			end
			hrb_pkg::HRB_XB_EXPIRED: begin
				// Wait until every phase is clear
				if (!any_restraint) begin
					next_st.xb_state = hrb_pkg::HRB_XB_IDLE;
				end
			end
			default: begin
				next_st.xb_state = hrb_pkg::HRB_XB_IDLE;
			end
		endcase

		// Summary flags
		next_st.any2 = |inr;
		next_st.any5 = |h5_raw;

		// Element blocking: own restraint always, all phases in cross mode
		if (st.xen && st.xb_state == hrb_pkg::HRB_XB_ACTIVE && any_restraint) begin
			next_st.block = 3'b111;
		end else begin
			next_st.block = own_block;
		end
		next_st.trip = elem_start_in & ~next_st.block;
	end

	// State register with documented setting defaults
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			st          <= '0;
			st.xen      <= `HRB_XEN_RST;
			st.f60      <= `HRB_F60_RST;
			st.thr2     <= `HRB_THR2_RST;
			st.thr5     <= `HRB_THR5_RST;
			st.xlimit   <= `HRB_XLIMIT_RST;
			st.min_diff <= `HRB_MIN_DIFF_RST;
			st.xb_state <= hrb_pkg::HRB_XB_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign prdata_out                          = st.prdata;
	assign pready_out                          = 1'b1;
	assign pslverr_out                         = access && st.pslverr;
	assign second_harm_restraint_out           = h2_raw;
	assign inrush_restraint_out                = inr;
	assign fifth_harm_restraint_out            = h5_raw;
	assign any_phase_second_harm_restraint_out = st.any2;
	assign any_phase_fifth_harm_restraint_out  = st.any5;
	assign cross_block_active_out              = st.xb_state == hrb_pkg::HRB_XB_ACTIVE;
	assign elem_block_out                      = st.block;
	assign elem_trip_req_out                   = st.trip;
endmodule : hrb_top

// File: tb/hrb_est_model.sv
// Upstream harmonic estimators: per phase magnitudes from requested levels
module hrb_est_model (
	input  wire logic        sys_clk_in,
	input  wire logic [2:0]  hi2_in,     // Phases with high second content
	input  wire logic [2:0]  hi5_in,     // Phases with high fifth content
	input  wire logic [15:0] fund_in,    // Fundamental level of every phase
	output logic      [47:0] fund_out,
	output logic      [47:0] second_out,
	output logic      [47:0] fifth_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Quiet estimates until the first refresh
	initial begin
		fund_out = '0;
		second_out = '0;
		fifth_out = '0;
	end
	// Refreshed once a clock, so each level change lands one cycle late
	always @(posedge sys_clk_in) begin
		for (int p = 0; p < 3; p++) begin
			fund_out[p*16 +: 16] <= fund_in;
			second_out[p*16 +: 16] <= hi2_in[p] ? fund_in / 5 : fund_in / 10;
			fifth_out[p*16 +: 16] <= hi5_in[p] ? fund_in * 3 / 10 : fund_in / 10;
		end
	end
endmodule : hrb_est_model

// File: tb/hrb_top_sva.sv
// Port-level checker of the restraint and blocking outputs
module hrb_top_sva #(
	parameter int MAG_W       = 16,
	parameter int CLKS_PER_MS = 20000
) (
	input wire logic       sys_clk_in,
	input wire logic       srst_in,
	input wire logic       psel_in,
	input wire logic       penable_in,
	input wire logic       pslverr_out,
	input wire logic       inrush_cond_in,
	input wire logic       ext_fault_cond_in,
	input wire logic [2:0] elem_start_in,
	input wire logic [2:0] second_harm_restraint_out,
	input wire logic [2:0] inrush_restraint_out,
	input wire logic [2:0] fifth_harm_restraint_out,
	input wire logic       any_phase_second_harm_restraint_out,
	input wire logic       any_phase_fifth_harm_restraint_out,
	input wire logic       cross_block_active_out,
	input wire logic [2:0] elem_block_out,
	input wire logic [2:0] elem_trip_req_out
);
	localparam int XB_MAX = 60000 * CLKS_PER_MS + 4; // Longest legal cross-block run
	logic [2:0]  own;    // Each phase's own restraint
	logic [31:0] xb_run; // Cycles spent cross-blocking
	assign own = inrush_restraint_out | fifth_harm_restraint_out;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	// Length of the current cross-block run
	always_ff @(posedge sys_clk_in) begin
		if (srst_in || !cross_block_active_out)
			xb_run <= '0;
		else
			xb_run <= xb_run + 32'h1;
	end
	property p_gate2; inrush_restraint_out == (second_harm_restraint_out & {3{inrush_cond_in | ext_fault_cond_in}});
	endproperty
	a_gate2: assert property (p_gate2) else $error("gated restraint wrong");
	property p_any2; any_phase_second_harm_restraint_out == |$past(inrush_restraint_out); endproperty
	a_any2: assert property (p_any2) else $error("second summary wrong");
	property p_any5; any_phase_fifth_harm_restraint_out == |$past(fifth_harm_restraint_out); endproperty
	a_any5: assert property (p_any5) else $error("fifth summary wrong");
	// Block follows the restraint seen one edge earlier, so an episode that ends frees the phases
	property p_xall; cross_block_active_out && |own |=> elem_block_out == 3'h7; endproperty
	a_xall: assert property (p_xall) else $error("cross block missed a phase");
	property p_trip; elem_trip_req_out == ($past(elem_start_in) & ~elem_block_out); endproperty
	a_trip: assert property (p_trip) else $error("trip request ignores block");
	property p_own; !$past(cross_block_active_out) |-> elem_block_out == $past(own); endproperty
	a_own: assert property (p_own) else $error("own block wrong");
	property p_xcause; $rose(cross_block_active_out) |-> $past(|own); endproperty
	a_xcause: assert property (p_xcause) else $error("cross block without restraint");
	property p_xlim; xb_run <= XB_MAX; endproperty
	a_xlim: assert property (p_xlim) else $error("cross block too long");
	property p_err; pslverr_out |-> psel_in && penable_in; endproperty
	a_err: assert property (p_err) else $error("error outside access");
endmodule : hrb_top_sva

bind hrb_top hrb_top_sva #(.MAG_W(MAG_W), .CLKS_PER_MS(CLKS_PER_MS)) u_sva (
	.sys_clk_in, .srst_in, .psel_in, .penable_in, .pslverr_out, .inrush_cond_in,
	.ext_fault_cond_in, .elem_start_in, .second_harm_restraint_out, .inrush_restraint_out,
	.fifth_harm_restraint_out, .any_phase_second_harm_restraint_out,
	.any_phase_fifth_harm_restraint_out, .cross_block_active_out, .elem_block_out, .elem_trip_req_out
);

// File: tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk_in  = 1'b0;
	logic        srst_in     = 1'b1;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [7:0]  paddr       = 8'h00;
	logic [31:0] pwdata      = 32'h0;
	logic [2:0]  hi2         = 3'h0; // Phases given high second content
	logic [2:0]  hi5         = 3'h0; // Phases given high fifth content
	logic        inrush      = 1'b0;
	logic        ext_fault   = 1'b0;
	logic [2:0]  start       = 3'h0; // Random start requests
	int          seed        = 32'h1ad38a20;
	int          fund_lvl    = 1000;
	int          errors      = 0;
	int          check_count = 0;
	int          regs [5]    = '{1, 15, 25, 5000, 0}; // Register model, index is offset/4
	int          wa [4]      = '{4, 4, 12, 4};        // Clamp table: address
	int          wd [4]      = '{2, 60, 10, 15};      // Clamp table: data
	logic [47:0] fund_mag, second_mag, fifth_mag;
	logic [31:0] prdata;
	logic        pready, pslverr, any2, any5, xact;
	logic [2:0]  h2, inr, h5, blk, trip;

	always #25 sys_clk_in = ~sys_clk_in;
	// Start requests change every cycle so trip gating is always exercised
	always @(posedge sys_clk_in) start <= 3'($random(seed));

	hrb_est_model est (.sys_clk_in(sys_clk_in), .hi2_in(hi2), .hi5_in(hi5), .fund_in(16'(fund_lvl)),
		.fund_out(fund_mag), .second_out(second_mag), .fifth_out(fifth_mag));
	hrb_top #(.MAG_W(16), .CLKS_PER_MS(20), .CLKS_PER_TK60(17)) dut (.sys_clk_in(sys_clk_in),
		.srst_in(srst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.fund_mag_in(fund_mag), .second_mag_in(second_mag), .fifth_mag_in(fifth_mag),
		.inrush_cond_in(inrush), .ext_fault_cond_in(ext_fault), .elem_start_in(start),
		.second_harm_restraint_out(h2), .inrush_restraint_out(inr), .fifth_harm_restraint_out(h5),
		.any_phase_second_harm_restraint_out(any2), .any_phase_fifth_harm_restraint_out(any5),
		.cross_block_active_out(xact), .elem_block_out(blk), .elem_trip_req_out(trip));

	task automatic wrap_up();
		if (errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : chk
	// Expected restraint per phase from the magnitudes the estimators give
	function automatic logic [2:0] model_r(logic [2:0] hv, int pct, int thr);
		for (int p = 0; p < 3; p++)
			model_r[p] = (hv[p] ? fund_lvl * pct / 100 : fund_lvl / 10) * 100 > thr * fund_lvl;
	endfunction : model_r
	// Settings clamp into their legal ranges rather than fault
	function automatic int clampv(int i, int d);
		if (i == 1 || i == 2)
			return d < 5 ? 5 : (d > 50 ? 50 : d);
		if (i == 3)
			return d < 100 ? 100 : (d > 60000 ? 60000 : d);
		return i == 0 ? d & 3 : d & 32'hffff;
	endfunction : clampv
	// One APB transfer; the wait on pready is bounded
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		@(posedge sys_clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_in);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge sys_clk_in);
			if (pready === 1'b1)
				break;
		end
		if (n == 16) begin
			errors++;
			wrap_up();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input int d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		regs[a/4] = clampv(a / 4, d);
		chk(e, 0, "write error");
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 0, r, e);
		chk(r, regs[a/4], "read data");
		chk(e, 0, "read error");
	endtask : rd
	task automatic drive(input logic [2:0] s2, input logic [2:0] s5, input logic ir, input logic ef);
		@(posedge sys_clk_in);
		hi2 <= s2;
		hi5 <= s5;
		inrush <= ir;
		ext_fault <= ef;
	endtask : drive
	// Waits end at a falling edge, where outputs are settled
	task automatic tk(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask : tk
	task automatic pulse(input int n);
		drive(3'h1, 3'h0, 1'b0, 1'b0);
		tk(n);
		drive(3'h0, 3'h0, 1'b0, 1'b0);
	endtask : pulse

	// Hang guard
	initial begin
		repeat (60000) @(posedge sys_clk_in);
		errors++;
		wrap_up();
	end
	initial begin
		logic [31:0] r;
		logic        e;
		fund_lvl = 500 + {$random(seed)} % 1000;
		repeat (8) @(posedge sys_clk_in);
		srst_in <= 1'b0;
		for (int a = 0; a < 5; a++)
			rd(8'(a * 4));
		apb(1'b0, 8'h18, 32'h0, r, e);
		chk(e, 1, "unmapped not refused");
		for (int i = 0; i < 4; i++) begin
			wr(8'(wa[i]), wd[i]);
			rd(8'(wa[i]));
		end
		// Individual blocking, second path gated by either condition
		wr(8'h00, 0);
		drive(3'h5, 3'h0, 1'b1, 1'b0);
		tk(4);
		chk(h2, model_r(hi2, 20, regs[1]), "second restraint");
		chk(inr, 3'h5, "inrush restraint");
		chk(any2, 1, "second summary");
		chk(blk, 3'h5, "own block");
		drive(3'h5, 3'h0, 1'b0, 1'b0);
		tk(4);
		chk(inr, 3'h0, "ungated restraint");
		drive(3'h5, 3'h0, 1'b0, 1'b1);
		tk(4);
		chk(inr, 3'h5, "fault gated restraint");
		drive(3'h0, 3'h0, 1'b0, 1'b0);
		tk(300);
		// Qualification and drop-off at 50 Hz then 60 Hz
		for (int f = 0; f < 2; f++) begin
			wr(8'h00, f * 2);
			pulse(450);
			tk(100);
			chk(h2, f, "qualification");
			tk(300);
			pulse(600);
			tk(f ? 230 : 260);
			chk(h2, 1, "drop-off short");
			tk(60);
			chk(h2, 0, "drop-off long");
			tk(300);
		end
		// Fifth path needs the minimum differential current only
		wr(8'h10, 2000);
		drive(3'h0, 3'h2, 1'b0, 1'b0);
		tk(4);
		chk(h5, 3'h0, "fifth below minimum");
		wr(8'h10, 0);
		tk(4);
		chk(h5, model_r(hi5, 30, regs[2]), "fifth restraint");
		chk(any5, 1, "fifth summary");
		chk(blk, 3'h2, "fifth own block");
		drive(3'h0, 3'h0, 1'b0, 1'b0);
		tk(300);
		// Cross-blocking for the 100 ms limit, then self-blocking only
		wr(8'h00, 1);
		drive(3'h0, 3'h2, 1'b0, 1'b0);
		tk(6);
		chk(xact, 1, "cross block off");
		chk(blk, 3'h7, "cross block");
		chk(trip, 3'h0, "trip while blocked");
		tk(1960);
		chk(xact, 1, "cross block early end");
		tk(50);
		chk(xact, 0, "cross block limit");
		chk(blk, 3'h2, "self block after limit");
		// The fifth path qualified during the long episode, so wait out its drop-off first
		drive(3'h0, 3'h0, 1'b0, 1'b0);
		tk(320);
		drive(3'h4, 3'h0, 1'b1, 1'b0);
		tk(6);
		chk(blk, 3'h7, "second cross block");
		drive(3'h0, 3'h0, 1'b0, 1'b0);
		tk(4);
		wrap_up();
	end
endmodule : tb
